// >>> hw/swts_pkg.sv
package swts_pkg;
	// bus timing, in microseconds, and the clock rate
	localparam int CLK_MHZ        = 200;
	localparam int T_RST_DET_US   = 400;
	localparam int T_PRES_WAIT_US = 15;
	localparam int T_PRES_LOW_US  = 120;
	localparam int T_SAMPLE_US    = 30;
	localparam int T_HOLD_US      = 40;
	localparam int RST_DET_CYC    = T_RST_DET_US * CLK_MHZ;
	localparam int PRES_WAIT_CYC  = T_PRES_WAIT_US * CLK_MHZ;
	localparam int PRES_LOW_CYC   = T_PRES_LOW_US * CLK_MHZ;
	localparam int SAMPLE_CYC     = T_SAMPLE_US * CLK_MHZ;
	localparam int HOLD_CYC       = T_HOLD_US * CLK_MHZ;
	// register stack byte offsets and reset values
	localparam logic [2:0] OFS_TEMP_LO = 3'h1;
	localparam logic [2:0] OFS_TEMP_HI = 3'h2;
	localparam logic [2:0] OFS_UPPER   = 3'h3;
	localparam logic [2:0] OFS_LOWER   = 3'h4;
	localparam logic [2:0] OFS_CFG     = 3'h5;
	localparam logic [2:0] OFS_CRC     = 3'h6;
	localparam logic [7:0] RST_TEMP_LO = 8'h50;
	localparam logic [7:0] RST_TEMP_HI = 8'h05;
	localparam logic [7:0] RST_UPPER   = 8'h55;
	localparam logic [7:0] RST_LOWER   = 8'h00;
	localparam logic [7:0] RST_CFG     = 8'h7f;
	localparam logic [7:0] RST_CRC     = 8'he3;
	localparam int         CFG_EXT_BIT = 7;
	localparam logic [6:0] CFG_RSVD    = 7'h7f;
	// result spans in sixteenths of a degree
	localparam logic [15:0] NORM_MAX = 16'h07ff;
	localparam logic [15:0] NORM_MIN = 16'hf800;
	localparam logic [15:0] EXT_MAX  = 16'h0fff;
	localparam logic [15:0] EXT_MIN  = 16'hf000;
	// command codes
	localparam logic [7:0] CMD_SEARCH       = 8'hf0;
	localparam logic [7:0] CMD_ALARM_SEARCH = 8'hec;
	localparam logic [7:0] CMD_READ_ADDR    = 8'h33;
	localparam logic [7:0] CMD_MATCH_ADDR   = 8'h55;
	localparam logic [7:0] CMD_SKIP_ADDR    = 8'hcc;
	localparam logic [7:0] CMD_CONVERT      = 8'h44;
	localparam logic [7:0] CMD_READ_STACK   = 8'hbe;
	localparam logic [7:0] CMD_WRITE_STACK  = 8'h4e;
	// last bit index of each transfer, one below its bit count
	localparam logic [5:0] LAST_CMD_BIT   = 6'h07;
	localparam logic [5:0] LAST_ADDR_BIT  = 6'h3f;
	localparam logic [5:0] LAST_STACK_BIT = 6'h2f;
	localparam logic [5:0] LAST_WR_BIT    = 6'h17;
	localparam logic [1:0] SEARCH_PICK    = 2'h2;
	localparam logic [7:0] CRC_POLY_REFL  = 8'h8c;
	localparam int         ADDR_CRC_BITS  = 56;
	localparam int         STACK_CRC_BITS = 40;
	localparam int         FIFO_WIDTH     = 16;
	localparam int         FIFO_DEPTH     = 16;

	typedef enum logic [3:0] {
		ST_IDLE, ST_PRES_WAIT, ST_PRES, ST_ADDR_CMD, ST_ADDR_READ, ST_ADDR_MATCH,
		ST_SEARCH, ST_FUNC_CMD, ST_STACK_RD, ST_STACK_WR
	} swts_state_t;

	// lsb-first crc over the low nbits of data, zero start
	function automatic logic [7:0] swts_stack_checksum(input logic [55:0] data, input int nbits);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 56; i++) begin
			if (i < nbits) begin
				if (c[0] ^ data[i]) begin
					c = (c >> 1) ^ CRC_POLY_REFL;
				end else begin
					c = c >> 1;
				end
			end
		end
		return c;
	endfunction
endpackage

// >>> hw/swts_top.sv
`timescale 1ns/1ps
// Contract
// [R01] temperature kept as 16-bit sign-extended two's complement, lsb sixteenth degree
// [R02] temperature reads 0x0550 after reset until first conversion lands
// [R03] master sets extended range before trusting readings at or above 128 degrees
// [R04] normal range spans -128 to 127.9375, hotter saturates at 0x07ff
// [R05] extended range spans -256 to 255.9375, 150 degrees reads 0x0960
// [R06] range bit changes span only, never resolution
// [R07] normal range: bits 15..11 sign, bit 10 weighs 64, bits 3..0 fraction
// [R08] extended range: bits 15..12 sign, bit 11 weighs 128
// [R09] normal range limit byte: bit 7 sign, bits 6..0 weigh 64 to 1
// [R10] extended range limit byte: bit 7 sign, bits 6..0 weigh 128 to 2
// [R11] config bit 7 writable range select, reset 0; bits 6..0 read one
// [R12] sixth stack byte is crc over first five, read only
// [R13] data line driven only as open drain
// [R14] every byte on the line moves least significant bit first
// [R15] addressing command selects first, only then a function command runs
// [R16] decode addressing codes f0, ec, 33, 55, cc
// [R17] decode function codes 44 convert, be read stack, 4e write stack
// [R18] node address: type code 7..0, serial 55..8, crc 63..56
// [R19] master resets with 480 us low, device answers with presence low
// [R20] slots at least 65 us, 1 us recovery, start with master low
// [R21] read slot: zero held low 15 to 60 us, one leaves line released
// [R22] master write zero holds 60 us, write one releases within 15 us
// [R23] both crcs use x^8+x^5+x^4+1, lsb first, zero start

module swts_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             i_clk,       // system clock
	input  wire logic             i_resetn,    // async reset, low
	input  wire logic             i_in_valid,  // source offers a word
	input  wire logic [WIDTH-1:0] i_in_data,   // source word
	output logic                  o_in_ready,  // room for a word
	output logic                  o_out_valid, // a word waits
	output logic      [WIDTH-1:0] o_out_data,  // oldest word
	input  wire logic             i_out_ready  // sink takes the word
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	// honest flags straight from the occupancy count
	assign o_in_ready  = count_reg != (AW + 1)'(DEPTH);
	assign o_out_valid = count_reg != '0;
	assign o_out_data  = mem_reg[rd_ptr_reg];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	// pointers wrap naturally, depth must be a power of two
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

	// one storage word per entry
	for (genvar g = 0; g < DEPTH; g++) begin : g_ent
		always_ff @(posedge i_clk or negedge i_resetn) begin
			if (!i_resetn) begin
				mem_reg[g] <= '0;
			end else if (push && wr_ptr_reg == AW'(g)) begin
				mem_reg[g] <= i_in_data;
			end
		end
	end
endmodule

module swts_top #(
	parameter int          P_RST_DET_CYC  = swts_pkg::RST_DET_CYC,
	parameter int          P_PRES_LOW_CYC = swts_pkg::PRES_LOW_CYC,
	parameter int          P_SAMPLE_CYC   = swts_pkg::SAMPLE_CYC,
	parameter int          P_HOLD_CYC     = swts_pkg::HOLD_CYC,
	parameter logic [7:0]  P_TYPE_CODE    = 8'h3c,              // arbitrary value
	parameter logic [47:0] P_SERIAL       = 48'h0000_0000_0001  // arbitrary value
) (
	input  wire logic        i_clk,        // 200 MHz clock
	input  wire logic        i_resetn,     // async reset, low
	input  wire logic        i_dq,         // data line level seen at the pin
	output logic             o_dq,         // data line drive value, always low
	output logic             o_dq_oe,      // high while pulling the line low
	input  wire logic        i_meas_valid, // converter offers a result
	input  wire logic [15:0] i_meas_data,  // raw result, sixteenths of a degree
	output logic             o_meas_ready, // result buffer has room
	output logic             o_conv_start, // one-cycle conversion request
	output logic             o_alarm,      // last result beyond the limits
	output logic             o_ext_range   // extended range selected
);
	localparam int CW = 24;

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	swts_pkg::swts_state_t state_reg;
	logic [2:0]  dq_sync_reg;
	logic        dq_lvl_reg;
	logic        dq_prev_reg;
	logic        dq_fall;
	logic        dq_rise;
	logic [CW-1:0] low_cnt_reg;
	logic        rst_seen;
	logic [CW-1:0] slot_cnt_reg;
	logic        slot_act_reg;
	logic        bit_evt;
	logic [CW-1:0] tmr_reg;
	logic [5:0]  idx_reg;
	logic [1:0]  phase_reg;
	logic [7:0]  sh_reg;
	logic [7:0]  byte_in;
	logic        tx_bit;
	logic        oe_reg;
	logic        conv_reg;
	logic [15:0] temp_reg;
	logic [15:0] temp_next;
	logic [7:0]  upper_reg;
	logic [7:0]  lower_reg;
	logic        ext_reg;
	logic        alarm_reg;
	logic        alarm_next;
	logic        loaded_reg;
	logic [7:0]  cfg_byte;
	logic [7:0]  crc_byte;
	logic [47:0] stack_bits;
	logic [63:0] node_addr;
	logic        fifo_valid;
	logic [15:0] fifo_data;
	logic        fifo_take;
	logic        wr_byte_evt;

	// node address, checksum over type code and serial
	assign node_addr = {swts_pkg::swts_stack_checksum({P_SERIAL, P_TYPE_CODE}, swts_pkg::ADDR_CRC_BITS),
		P_SERIAL, P_TYPE_CODE};                                    // see [R18] see [R23]

	// register stack image, byte one in the low bits
	assign cfg_byte   = {ext_reg, swts_pkg::CFG_RSVD};              // see [R11]
	assign crc_byte   = swts_pkg::swts_stack_checksum({16'h0000, cfg_byte, lower_reg, upper_reg, temp_reg},
		swts_pkg::STACK_CRC_BITS);                                  // see [R12] see [R23]
	assign stack_bits = {crc_byte, cfg_byte, lower_reg, upper_reg, temp_reg};

	// pin input: three stages, a change counts once stages two and three agree
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			dq_sync_reg <= 3'h7;
			dq_lvl_reg  <= 1'b1;
			dq_prev_reg <= 1'b1;
		end else begin
			dq_sync_reg <= {dq_sync_reg[1:0], i_dq};
			dq_prev_reg <= dq_lvl_reg;
			if (dq_sync_reg[1] == dq_sync_reg[2]) begin
				dq_lvl_reg <= dq_sync_reg[2];
			end
		end
	end
	assign dq_fall = dq_prev_reg && !dq_lvl_reg;
	assign dq_rise = !dq_prev_reg && dq_lvl_reg;

	// low-time counter, saturates so a long hold cannot wrap
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			low_cnt_reg <= '0;
		end else if (dq_lvl_reg) begin
			low_cnt_reg <= '0;
		end else if (!rst_seen) begin
			low_cnt_reg <= low_cnt_reg + 1'b1;
		end
	end
	assign rst_seen = low_cnt_reg >= CW'(P_RST_DET_CYC);               // see [R19]

	// slot timer, started by every falling edge of the master
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			slot_act_reg <= 1'b0;
			slot_cnt_reg <= '0;
		end else if (dq_fall) begin
			slot_act_reg <= 1'b1;                                       // see [R20]
			slot_cnt_reg <= '0;
		end else if (slot_act_reg) begin
			slot_cnt_reg <= slot_cnt_reg + 1'b1;
			if (slot_cnt_reg == CW'(P_HOLD_CYC)) begin
				slot_act_reg <= 1'b0;
			end
		end
	end
	// one sample per slot, well past the master's write-one release
	assign bit_evt = slot_act_reg && slot_cnt_reg == CW'(P_SAMPLE_CYC); // see [R22]
	assign byte_in = {dq_lvl_reg, sh_reg[7:1]};                        // see [R14]

	// bit offered in read slots; receive states offer one so they never drive
	always_comb begin
		case (state_reg)
			swts_pkg::ST_ADDR_READ: tx_bit = node_addr[idx_reg];
			swts_pkg::ST_SEARCH: begin
				tx_bit = (phase_reg == 2'h0) ? node_addr[idx_reg] : !node_addr[idx_reg];
				if (phase_reg == swts_pkg::SEARCH_PICK) begin
					tx_bit = 1'b1;
				end
			end
			swts_pkg::ST_STACK_RD: tx_bit = (idx_reg > swts_pkg::LAST_STACK_BIT) ? 1'b1 : stack_bits[idx_reg];
			default: tx_bit = 1'b1;
		endcase
	end

	// protocol sequencer; a recognised reset pulse overrides any state
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg <= swts_pkg::ST_IDLE;
			tmr_reg   <= '0;
			idx_reg   <= '0;
			phase_reg <= '0;
			sh_reg    <= '0;
		end else if (dq_rise && rst_seen) begin
			state_reg <= swts_pkg::ST_PRES_WAIT;                          // see [R19]
			tmr_reg   <= '0;
			idx_reg   <= '0;
			phase_reg <= '0;
		end else begin
			case (state_reg)
				swts_pkg::ST_PRES_WAIT: begin
					tmr_reg <= tmr_reg + 1'b1;
					if (tmr_reg == CW'(swts_pkg::PRES_WAIT_CYC)) begin
						state_reg <= swts_pkg::ST_PRES;
						tmr_reg   <= '0;
					end
				end
				swts_pkg::ST_PRES: begin
					tmr_reg <= tmr_reg + 1'b1;
					if (tmr_reg == CW'(P_PRES_LOW_CYC)) begin
						state_reg <= swts_pkg::ST_ADDR_CMD;                   // see [R15]
					end
				end
				swts_pkg::ST_ADDR_CMD: begin
					if (bit_evt) begin
						sh_reg  <= byte_in;
						idx_reg <= idx_reg + 1'b1;
						if (idx_reg == swts_pkg::LAST_CMD_BIT) begin
							idx_reg <= '0;
							case (byte_in)                                    // see [R16]
								swts_pkg::CMD_READ_ADDR:  state_reg <= swts_pkg::ST_ADDR_READ;
								swts_pkg::CMD_MATCH_ADDR: state_reg <= swts_pkg::ST_ADDR_MATCH;
								swts_pkg::CMD_SKIP_ADDR:  state_reg <= swts_pkg::ST_FUNC_CMD;
								swts_pkg::CMD_SEARCH:     state_reg <= swts_pkg::ST_SEARCH;
								swts_pkg::CMD_ALARM_SEARCH: begin
									state_reg <= alarm_reg ? swts_pkg::ST_SEARCH : swts_pkg::ST_IDLE;
								end
								default: state_reg <= swts_pkg::ST_IDLE;
							endcase
						end
					end
				end
				swts_pkg::ST_ADDR_READ: begin
					if (bit_evt) begin
						idx_reg <= idx_reg + 1'b1;
						if (idx_reg == swts_pkg::LAST_ADDR_BIT) begin
							state_reg <= swts_pkg::ST_FUNC_CMD;
						end
					end
				end
				swts_pkg::ST_ADDR_MATCH: begin
					if (bit_evt) begin
						idx_reg <= idx_reg + 1'b1;
						if (dq_lvl_reg != node_addr[idx_reg]) begin
							state_reg <= swts_pkg::ST_IDLE;
						end else if (idx_reg == swts_pkg::LAST_ADDR_BIT) begin
							state_reg <= swts_pkg::ST_FUNC_CMD;
						end
					end
				end
				swts_pkg::ST_SEARCH: begin
					// true bit, inverted bit, then the master's pick; losers drop out
					if (bit_evt) begin
						phase_reg <= phase_reg + 1'b1;
						if (phase_reg == swts_pkg::SEARCH_PICK) begin
							phase_reg <= '0;
							idx_reg   <= idx_reg + 1'b1;
							if (dq_lvl_reg != node_addr[idx_reg] || idx_reg == swts_pkg::LAST_ADDR_BIT) begin
								state_reg <= swts_pkg::ST_IDLE;
							end
						end
					end
				end
				swts_pkg::ST_FUNC_CMD: begin
					if (bit_evt) begin
						sh_reg  <= byte_in;
						idx_reg <= idx_reg + 1'b1;
						if (idx_reg == swts_pkg::LAST_CMD_BIT) begin
							idx_reg <= '0;
							case (byte_in)                                    // see [R17]
								swts_pkg::CMD_READ_STACK:  state_reg <= swts_pkg::ST_STACK_RD;
								swts_pkg::CMD_WRITE_STACK: state_reg <= swts_pkg::ST_STACK_WR;
								default:                   state_reg <= swts_pkg::ST_IDLE;
							endcase
						end
					end
				end
				swts_pkg::ST_STACK_RD: begin
					if (bit_evt) begin
						idx_reg <= idx_reg + 1'b1;
						if (idx_reg == swts_pkg::LAST_STACK_BIT) begin
							state_reg <= swts_pkg::ST_IDLE;
						end
					end
				end
				swts_pkg::ST_STACK_WR: begin
					if (bit_evt) begin
						sh_reg  <= byte_in;
						idx_reg <= idx_reg + 1'b1;
						if (idx_reg == swts_pkg::LAST_WR_BIT) begin
							state_reg <= swts_pkg::ST_IDLE;
						end
					end
				end
				default: state_reg <= swts_pkg::ST_IDLE;
			endcase
		end
	end

	// line drive: presence pulse, or a zero in a read slot
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			oe_reg <= 1'b0;
		end else if (state_reg == swts_pkg::ST_PRES_WAIT && tmr_reg == CW'(swts_pkg::PRES_WAIT_CYC)) begin
			oe_reg <= 1'b1;                                               // see [R19]
		end else if (state_reg == swts_pkg::ST_PRES && tmr_reg == CW'(P_PRES_LOW_CYC)) begin
			oe_reg <= 1'b0;
		end else if (dq_fall && !tx_bit) begin
			oe_reg <= 1'b1;                                               // see [R21]
		end else if (state_reg != swts_pkg::ST_PRES && slot_act_reg && slot_cnt_reg == CW'(P_HOLD_CYC)) begin
			oe_reg <= 1'b0;
		end
	end
	assign o_dq    = 1'b0;                                             // see [R13]
	assign o_dq_oe = oe_reg;

	// conversion request after the convert code
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			conv_reg <= 1'b0;
		end else begin
			conv_reg <= bit_evt && state_reg == swts_pkg::ST_FUNC_CMD
				&& idx_reg == swts_pkg::LAST_CMD_BIT && byte_in == swts_pkg::CMD_CONVERT;
		end
	end
	assign o_conv_start = conv_reg;

	// stack writes land byte by byte: upper, lower, then config
	assign wr_byte_evt = bit_evt && state_reg == swts_pkg::ST_STACK_WR && idx_reg[2:0] == 3'h7;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			upper_reg <= swts_pkg::RST_UPPER;
			lower_reg <= swts_pkg::RST_LOWER;
			ext_reg   <= swts_pkg::RST_CFG[swts_pkg::CFG_EXT_BIT];
		end else if (wr_byte_evt) begin
			case (idx_reg[4:3])
				2'h0:    upper_reg <= byte_in;                             // see [R09] see [R10]
				2'h1:    lower_reg <= byte_in;
				2'h2:    ext_reg   <= byte_in[swts_pkg::CFG_EXT_BIT];      // see [R03] see [R11]
				default: ext_reg   <= ext_reg;
			endcase
		end
	end
	assign o_ext_range = ext_reg;

	// results buffer; held back during a stack read so the bytes stay coherent
	swts_fifo #(
		.WIDTH (swts_pkg::FIFO_WIDTH),
		.DEPTH (swts_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clk       (i_clk),
		.i_resetn    (i_resetn),
		.i_in_valid  (i_meas_valid),
		.i_in_data   (i_meas_data),
		.o_in_ready  (o_meas_ready),
		.o_out_valid (fifo_valid),
		.o_out_data  (fifo_data),
		.i_out_ready (fifo_take)
	);
	assign fifo_take = state_reg != swts_pkg::ST_STACK_RD;

	// saturate to the selected span; the lsb weight never changes
	always_comb begin
		temp_next = fifo_data;                                          // see [R01] see [R06]
		if (ext_reg) begin
			if ($signed(fifo_data) > $signed(swts_pkg::EXT_MAX)) begin
				temp_next = swts_pkg::EXT_MAX;                              // see [R05] see [R08]
			end else if ($signed(fifo_data) < $signed(swts_pkg::EXT_MIN)) begin
				temp_next = swts_pkg::EXT_MIN;
			end
			alarm_next = $signed(temp_next[12:5]) > $signed(upper_reg)
				|| $signed(temp_next[12:5]) < $signed(lower_reg);       // see [R10]
		end else begin
			if ($signed(fifo_data) > $signed(swts_pkg::NORM_MAX)) begin
				temp_next = swts_pkg::NORM_MAX;                             // see [R04] see [R07]
			end else if ($signed(fifo_data) < $signed(swts_pkg::NORM_MIN)) begin
				temp_next = swts_pkg::NORM_MIN;
			end
			alarm_next = $signed(temp_next[11:4]) > $signed(upper_reg)
				|| $signed(temp_next[11:4]) < $signed(lower_reg);       // see [R09]
		end
	end

	// temperature and alarm follow each finished conversion
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			temp_reg   <= {swts_pkg::RST_TEMP_HI, swts_pkg::RST_TEMP_LO}; // see [R02]
			alarm_reg  <= 1'b0;
			loaded_reg <= 1'b0;
		end else if (fifo_valid && fifo_take) begin
			temp_reg   <= temp_next;
			alarm_reg  <= alarm_next;
			loaded_reg <= 1'b1;
		end
	end
	assign o_alarm = alarm_reg;

	AST_TEMP_RESET: assert property (!loaded_reg |-> temp_reg == 16'h0550) // see [R02]
		else $error("temperature left reset value before a conversion");
	AST_NORM_SAT: assert property (fifo_valid && fifo_take && !ext_reg && $signed(fifo_data) > 16'sh07ff
		|=> temp_reg == 16'h07ff) // see [R04]
		else $error("normal range result not saturated");
	AST_NORM_SIGN: assert property ($past(fifo_valid && fifo_take && !ext_reg)
		|-> temp_reg[15:11] == {5{temp_reg[11]}}) // see [R07]
		else $error("normal range sign copies broken");
	AST_EXT_SIGN: assert property ($past(fifo_valid && fifo_take && ext_reg)
		|-> temp_reg[15:12] == {4{temp_reg[12]}}) // see [R08]
		else $error("extended range sign copies broken");
	AST_CFG_RSVD: assert property (stack_bits[38:32] == 7'h7f) // see [R11]
		else $error("reserved config bits not read as one");
	AST_OPEN_DRAIN: assert property (o_dq_oe |-> o_dq == 1'b0) // see [R13]
		else $error("line driven high");
	AST_HOLD_ZERO: assert property ($rose(o_dq_oe) && state_reg != swts_pkg::ST_PRES |-> o_dq_oe[*8]) // see [R21]
		else $error("read zero released too early");
	AST_PRESENCE: assert property ($rose(o_dq_oe) && state_reg == swts_pkg::ST_PRES |-> o_dq_oe[*8]) // see [R19]
		else $error("presence pulse too short");
	AST_LSB_FIRST: assert property (bit_evt && state_reg == swts_pkg::ST_FUNC_CMD
		|=> sh_reg[7] == $past(dq_lvl_reg)) // see [R14]
		else $error("received bit not shifted in at the top");
	AST_CONVERT: assert property (bit_evt && state_reg == swts_pkg::ST_FUNC_CMD && idx_reg == 6'h07
		&& byte_in == 8'h44 |=> o_conv_start ##1 !o_conv_start) // see [R17]
		else $error("convert code gave no single request pulse");
endmodule

// >>> testbench/swts_master.sv
`timescale 1ns/1ps
module swts_master (
	input  wire logic i_clk,  // system clock
	input  wire logic i_line, // resolved line level
	output logic      o_pull  // high while master pulls low
);
	initial o_pull = 1'b0;
	// reset pulse, presence sampled well inside its window
	task automatic bus_reset(output logic seen);
		o_pull = 1'b1;
		repeat (210) @(negedge i_clk);
		o_pull = 1'b0;
		repeat (3020) @(negedge i_clk);
		seen = ~i_line;
		repeat (80) @(negedge i_clk);
	endtask
	// 55-cycle slot: short low writes one or reads, long low writes zero
	// a short low of 6 outlasts the device's input stages, so a read zero joins it without a glitch
	task automatic slot(input int lo, output logic b);
		o_pull = 1'b1;
		repeat (lo) @(negedge i_clk);
		o_pull = 1'b0;
		repeat (lo < 12 ? 12 - lo : 0) @(negedge i_clk);
		b = i_line;
		repeat (lo < 12 ? 43 : 25) @(negedge i_clk);
	endtask
	task automatic write_byte(input logic [7:0] d);
		logic b;
		for (int i = 0; i < 8; i++) slot(d[i] ? 6 : 30, b);
	endtask
	task automatic read_byte(output logic [7:0] d);
		for (int i = 0; i < 8; i++) slot(6, d[i]);
	endtask
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
	localparam logic [7:0]  TYPE_CODE = 8'h3c;         // design default, arbitrary value
	localparam logic [47:0] SERIAL    = 48'h00a5_0001; // arbitrary value
	logic        clk;
	logic        resetn;
	logic        meas_valid;
	logic        seen;
	logic        pull;
	logic        dq_o;
	logic        dq_oe;
	logic        meas_ready;
	logic        conv_start;
	logic        alarm;
	logic        ext;
	logic [15:0] meas_data;
	logic [7:0]  b;
	logic [47:0] s;
	logic [63:0] id;
	int          n_fail;
	int          total_checks;
	int          cycles;
	int          n_conv;
	wire         line;
	// open drain with pull-up: either party pulls low
	assign line = ~((dq_oe & ~dq_o) | pull);
	// short timings keep the run small; type code stays at its default
	swts_top #(
		.P_RST_DET_CYC  (200),
		.P_PRES_LOW_CYC (40),
		.P_SAMPLE_CYC   (20),
		.P_HOLD_CYC     (30),
		.P_SERIAL       (SERIAL)
	) uut (
		.i_clk        (clk),
		.i_resetn     (resetn),
		.i_dq         (line),
		.o_dq         (dq_o),
		.o_dq_oe      (dq_oe),
		.i_meas_valid (meas_valid),
		.i_meas_data  (meas_data),
		.o_meas_ready (meas_ready),
		.o_conv_start (conv_start),
		.o_alarm      (alarm),
		.o_ext_range  (ext)
	);
	swts_master mst (
		.i_clk  (clk),
		.i_line (line),
		.o_pull (pull)
	);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// count conversion pulses and cut a hang short
	always @(posedge clk) begin
		if (conv_start === 1'b1) n_conv++;
		cycles++;
		if (cycles == 90000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic [63:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			$display("mismatch at %0t: %h vs %h", $time, got, exp);
			n_fail++;
		end
	endtask
	// own reflected crc, zero start, kept apart from the design's
	function automatic logic [7:0] crc_ref(input logic [55:0] d, input int n);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < n; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
		return c;
	endfunction
	function automatic logic [47:0] stk(input logic [15:0] t, input logic [7:0] h, l, c);
		logic [39:0] d;
		d = {c, l, h, t};
		return {crc_ref({16'h0000, d}, 40), d};
	endfunction
	task automatic push(input logic [15:0] d);
		meas_valid = 1'b1;
		meas_data = d;
		while (meas_ready !== 1'b1) @(negedge clk);
		@(negedge clk);
		meas_valid = 1'b0;
	endtask
	task automatic rd_stack(input int skip);
		mst.bus_reset(seen);
		mst.write_byte(8'hcc);
		mst.write_byte(8'hbe);
		for (int i = skip; i < 6; i++) begin
			mst.read_byte(b);
			s[8*i +: 8] = b;
		end
	endtask
	task automatic wr_stack(input logic [7:0] h, l, c);
		mst.bus_reset(seen);
		mst.write_byte(8'hcc);
		mst.write_byte(8'h4e);
		mst.write_byte(h);
		mst.write_byte(l);
		mst.write_byte(c);
	endtask
	initial begin
		resetn = 1'b0;
		meas_valid = 1'b0;
		meas_data = 16'h0000;
		repeat (20) @(negedge clk);
		resetn = 1'b1;
		rd_stack(0);
		check(seen, 1'b1);
		check(s, stk(16'h0550, 8'h55, 8'h00, 8'h7f));
		check(s[47:40], 8'he3);
		// extended span: 150 degrees keeps its code, limits in 2-degree units
		wr_stack(8'h7d, 8'hc9, 8'h80);
		check(ext, 1'b1);
		push(16'h0960);
		rd_stack(0);
		check(s, stk(16'h0960, 8'h7d, 8'hc9, 8'hff));
		check(alarm, 1'b0);
		// normal span saturates both ways
		wr_stack(8'h7d, 8'hc9, 8'h00);
		check(ext, 1'b0);
		push(16'h0960);
		rd_stack(0);
		check(s, stk(16'h07ff, 8'h7d, 8'hc9, 8'h7f));
		check(alarm, 1'b1);
		push(16'hf000);
		rd_stack(0);
		check(s[15:0], 16'hf800);
		// stack read stalls draining: fill the buffer until it refuses
		rd_stack(5);
		meas_valid = 1'b1;
		for (int i = 0; i < 16; i++) begin
			meas_data = 16'h0010 + i;
			@(negedge clk);
		end
		meas_valid = 1'b0;
		check(meas_ready, 1'b0);
		rd_stack(0);
		check(s[15:0], 16'h001f);
		check(alarm, 1'b0);
		// alarm search with the alarm clear: no answer, though type bit 0 is zero
		mst.bus_reset(seen);
		mst.write_byte(8'hec);
		mst.slot(6, b[0]);
		check(b[0], 1'b1);
		// search: true bit, inverse bit, then a losing pick drops the device out
		mst.bus_reset(seen);
		mst.write_byte(8'hf0);
		mst.slot(6, b[0]);
		mst.slot(6, b[1]);
		mst.slot(TYPE_CODE[0] ? 30 : 6, b[2]);
		mst.slot(6, b[3]);
		check(b[1:0], {~TYPE_CODE[0], TYPE_CODE[0]});
		check(b[3], 1'b1);
		// node address, lsb first
		mst.bus_reset(seen);
		mst.write_byte(8'h33);
		for (int i = 0; i < 8; i++) begin
			mst.read_byte(b);
			id[8*i +: 8] = b;
		end
		check(id, {crc_ref({SERIAL, TYPE_CODE}, 56), SERIAL, TYPE_CODE});
		mst.bus_reset(seen);
		mst.write_byte(8'hcc);
		mst.write_byte(8'h44);
		repeat (10) @(negedge clk);
		check(n_conv, 1);
		// wrong address: no function command runs, line stays released
		mst.bus_reset(seen);
		mst.write_byte(8'h55);
		for (int i = 0; i < 8; i++) mst.write_byte(8'h00);
		mst.write_byte(8'hbe);
		mst.read_byte(b);
		check(b, 8'hff);
		report_and_stop();
	end
endmodule
